// >>> core/eiobp_pkg.sv
/*
  Shared constants of the extended I/O bank port.
  Assumes a 32-bit AXI4-Lite master with byte addressing.
*/
// How it works
// - 64 points in eight banks; direction set per bank only.
// - Banks 2 to 9 hold points 17 to 80.
// - Mask bit 1 makes its bank an output.
// - Mask bit 0 makes its bank an input.
// - Mask bit 0 is bank 2, bit 7 is bank 9.
// - Without a saved mask, startup makes all banks inputs.
// - Store saves mask and outputs; startup restores them.
// - Set and clear drive one point of 1-8, or of 17-80 in an output bank.
// - Conditional write drives one if nonzero, else zero.
// - Port write: general byte and four 16-bit values.
// - Values map to points 17-32, 33-48, 49-64, 65-80.
// - Port-write bits on input banks are dropped.
// - Addressed group's output-bank bits driven; others keep state.
// - Bank read of 0 or 2-9 returns a byte.
// - Bit query returns one point; 17 is bank 2 bit 0.
package eiobp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int BANKS    = 8;
  localparam int EXT_W    = 64;
  localparam int GEN_W    = 8;
  localparam int GROUPS   = 4;
  localparam int STORE_W  = EXT_W + GEN_W;
  localparam int PIN_SYNC_W = EXT_W + GEN_W + 1 + BANKS + STORE_W;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_DIR     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_GEN     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GRP0    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_BITCMD  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_BANKRD  = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_BITRD   = 8'h20;
  localparam logic [ADDR_W-1:0] REG_PERSIST = 8'h24;

  // ----------------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------------
  localparam int BIT_PT_LSB   = 0;
  localparam int BIT_OP_LSB   = 8;
  localparam int BIT_COND_LSB = 16;
  localparam int ERR_BIT      = 31;
  localparam logic [1:0] OP_SET  = 2'h0;
  localparam logic [1:0] OP_CLR  = 2'h1;
  localparam logic [1:0] OP_COND = 2'h2;
  localparam logic [6:0] PT_GEN_LO = 7'h01;
  localparam logic [6:0] PT_GEN_HI = 7'h08;
  localparam logic [6:0] PT_EXT_LO = 7'h11;
  localparam logic [6:0] PT_EXT_HI = 7'h50;
  localparam logic [3:0] BANK_GEN    = 4'h0;
  localparam logic [3:0] BANK_EXT_LO = 4'h2;
  localparam logic [3:0] BANK_EXT_HI = 4'h9;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and startup timing
  // ----------------------------------------------------------------
  localparam logic [BANKS-1:0]   DIR_RESET = 8'h00;
  localparam logic [STORE_W-1:0] OUT_RESET = '0;
  localparam logic [1:0]         LOAD_WAIT = 2'h3;

  typedef enum logic [1:0] {
    LD_WAIT  = 2'b00,
    LD_APPLY = 2'b01,
    LD_DONE  = 2'b11
  } eiobp_load_t;

endpackage

// >>> core/eiobp_sync.sv
/*
  Two-flop synchroniser for a bus of independent levels.
  Assumes each bit is a slow static level; no word coherence.
*/
module eiobp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  // ----------------------------------------------------------------
  // Two stages; only the second stage reads the first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// >>> core/eiobp_persist.sv
/*
  Startup restore and store strobe toward the nonvolatile store.
  Assumes the saved image inputs are already synchronised.
*/
module eiobp_persist
  import eiobp_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          savedValid,
  input  wire logic [eiobp_pkg::BANKS-1:0]   savedMask,
  input  wire logic [eiobp_pkg::STORE_W-1:0] savedOut,
  input  wire logic                          storeReq,
  input  wire logic [eiobp_pkg::BANKS-1:0]   curMask,
  input  wire logic [eiobp_pkg::STORE_W-1:0] curOut,
  output logic                               loadPulse,
  output logic      [eiobp_pkg::BANKS-1:0]   loadMask,
  output logic      [eiobp_pkg::STORE_W-1:0] loadOut,
  output logic                               loaded,
  output logic                               nvmStore,
  output logic      [eiobp_pkg::BANKS-1:0]   nvmStoreMask,
  output logic      [eiobp_pkg::STORE_W-1:0] nvmStoreOut
);
  eiobp_load_t ldState;
  logic [1:0]  waitCnt;

  // ----------------------------------------------------------------
  // Startup: let the synchronisers fill, then apply the image once
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ldState <= LD_WAIT;
      waitCnt <= 2'h0;
    end else begin
      unique case (ldState)
        LD_WAIT: begin
          waitCnt <= waitCnt + 2'h1;
          if (waitCnt == LOAD_WAIT) ldState <= LD_APPLY;
        end
        LD_APPLY: ldState <= LD_DONE;
        LD_DONE:  ldState <= LD_DONE;
        default:  ldState <= LD_WAIT;
      endcase
    end
  end

  // No saved image means all banks input, all outputs low
  assign loadPulse = (ldState == LD_APPLY);
  assign loaded    = (ldState == LD_DONE);
  assign loadMask  = savedValid ? savedMask : DIR_RESET;
  assign loadOut   = savedValid ? savedOut : OUT_RESET;

  // ----------------------------------------------------------------
  // Store strobe with registered image
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nvmStore     <= 1'b0;
      nvmStoreMask <= DIR_RESET;
      nvmStoreOut  <= OUT_RESET;
    end else begin
      nvmStore <= storeReq && loaded;
      if (storeReq && loaded) begin
        nvmStoreMask <= curMask;
        nvmStoreOut  <= curOut;
      end
    end
  end
endmodule

// >>> core/eiobp_port.sv
/*
  Extended I/O bank port: eight banks of eight points plus general I/O.
  Assumes async pins and a store that shows its image as static levels.
*/
module eiobp_port
  import eiobp_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic [eiobp_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [eiobp_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [eiobp_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [eiobp_pkg::DATA_W-1:0]  s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [eiobp_pkg::EXT_W-1:0]   ioIn,
  output logic      [eiobp_pkg::EXT_W-1:0]   ioOut,
  output logic      [eiobp_pkg::EXT_W-1:0]   ioOe,
  input  wire logic [eiobp_pkg::GEN_W-1:0]   genIn,
  output logic      [eiobp_pkg::GEN_W-1:0]   genOut,
  input  wire logic                          nvmValid,
  input  wire logic [eiobp_pkg::BANKS-1:0]   nvmMask,
  input  wire logic [eiobp_pkg::STORE_W-1:0] nvmOut,
  output logic                               nvmStore,
  output logic      [eiobp_pkg::BANKS-1:0]   nvmStoreMask,
  output logic      [eiobp_pkg::STORE_W-1:0] nvmStoreOut
);
  import eiobp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [BANKS-1:0]      dirMask;
  logic [EXT_W-1:0]      extOut;
  logic [EXT_W-1:0]      next_extOut;
  logic [GEN_W-1:0]      next_genOut;
  logic [BANKS-1:0]      next_dirMask;
  logic [EXT_W-1:0]      oeWide;
  logic [ADDR_W-1:0]     awAddr;
  logic                  awHeld;
  logic [DATA_W-1:0]     wData;
  logic [3:0]            wStrb;
  logic                  wHeld;
  logic                  doWrite;
  logic                  wrHit;
  logic                  storeReq;
  logic [3:0]            bankSel;
  logic [6:0]            pointSel;
  logic [PIN_SYNC_W-1:0] syncOut;
  logic [EXT_W-1:0]      ioInS;
  logic [GEN_W-1:0]      genInS;
  logic                  nvmValidS;
  logic [BANKS-1:0]      nvmMaskS;
  logic [STORE_W-1:0]    nvmOutS;
  logic                  loadPulse;
  logic [BANKS-1:0]      loadMask;
  logic [STORE_W-1:0]    loadOut;
  logic                  loaded;
  logic [DATA_W-1:0]     next_rdata;
  logic                  rdHit;
  logic [7:0]            wrPt;
  logic                  wrBit;

  // ----------------------------------------------------------------
  // Decoders: points for commands and queries, banks for queries only
  // ----------------------------------------------------------------
  // Point number to {valid, general, index}; 17 lands on bank 2 bit 0
  function automatic logic [7:0] decodePoint(input logic [6:0] p);
    logic [7:0] r;
    r = 8'h00;
    if (p >= PT_GEN_LO && p <= PT_GEN_HI)
      r = {2'b11, 6'(p - PT_GEN_LO)};
    else if (p >= PT_EXT_LO && p <= PT_EXT_HI)
      r = {2'b10, 6'(p - PT_EXT_LO)};
    return r;
  endfunction

  // Bank number to {valid, byte}; lowest point in bit 0
  function automatic logic [8:0] bankByte(input logic [3:0] b,
                                          input logic [EXT_W-1:0] ext,
                                          input logic [GEN_W-1:0] gen);
    logic [8:0] r;
    logic [2:0] k;
    r = 9'h000;
    k = 3'(b - BANK_EXT_LO);
    if (b == BANK_GEN)
      r = {1'b1, gen};
    else if (b >= BANK_EXT_LO && b <= BANK_EXT_HI)
      r = {1'b1, ext[k*8 +: 8]};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin and saved-image synchronisers
  // ----------------------------------------------------------------
  eiobp_sync #(.W(PIN_SYNC_W)) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .din     ({ioIn, genIn, nvmValid, nvmMask, nvmOut}),
    .dout    (syncOut)
  );
  assign {ioInS, genInS, nvmValidS, nvmMaskS, nvmOutS} = syncOut;

  // ----------------------------------------------------------------
  // Startup restore and store
  // ----------------------------------------------------------------
  eiobp_persist u_persist (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .savedValid   (nvmValidS),
    .savedMask    (nvmMaskS),
    .savedOut     (nvmOutS),
    .storeReq     (storeReq),
    .curMask      (dirMask),
    .curOut       ({extOut, genOut}),
    .loadPulse    (loadPulse),
    .loadMask     (loadMask),
    .loadOut      (loadOut),
    .loaded       (loaded),
    .nvmStore     (nvmStore),
    .nvmStoreMask (nvmStoreMask),
    .nvmStoreOut  (nvmStoreOut)
  );

  // ----------------------------------------------------------------
  // Bank direction fans out to whole banks, never single points
  // ----------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_oe
      assign oeWide[gb*8 +: 8] = {8{dirMask[gb]}};
    end
  endgenerate
  assign ioOe  = oeWide;
  assign ioOut = extOut;

  // ----------------------------------------------------------------
  // AXI write channel capture; address and data in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer with a slave error
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next output state from the pending write
  // ----------------------------------------------------------------
  always_comb begin
    next_dirMask = dirMask;
    next_genOut  = genOut;
    next_extOut  = extOut;
    wrHit        = 1'b0;
    storeReq     = 1'b0;
    wrPt         = decodePoint(wData[BIT_PT_LSB +: 7]);
    wrBit        = 1'b0;
    unique case (wData[BIT_OP_LSB +: 2])
      OP_SET:  wrBit = 1'b1;
      OP_CLR:  wrBit = 1'b0;
      OP_COND: wrBit = |wData[BIT_COND_LSB +: 16];
      default: wrBit = 1'b0;
    endcase
    if (awAddr == REG_DIR) begin
      wrHit        = 1'b1;
      next_dirMask = wData[BANKS-1:0];
    end
    if (awAddr == REG_GEN) begin
      wrHit       = 1'b1;
      next_genOut = wData[GEN_W-1:0];
    end
    // Only the addressed group changes; input-bank bits are dropped
    for (int g = 0; g < GROUPS; g++) begin
      if (awAddr == ADDR_W'(REG_GRP0 + 4 * g)) begin
        wrHit = 1'b1;
        next_extOut[g*16 +: 16] =
          (wData[15:0] & oeWide[g*16 +: 16]) |
          (extOut[g*16 +: 16] & ~oeWide[g*16 +: 16]);
      end
    end
    if (awAddr == REG_BITCMD) begin
      wrHit = 1'b1;
      if (wData[BIT_OP_LSB +: 2] != 2'h3 && wrPt[7]) begin
        if (wrPt[6])
          next_genOut[wrPt[2:0]] = wrBit;
        else if (oeWide[wrPt[5:0]])
          next_extOut[wrPt[5:0]] = wrBit;
      end
    end
    if (awAddr == REG_PERSIST) begin
      wrHit    = 1'b1;
      storeReq = doWrite && wStrb != 4'h0 && wData[0];
    end
    if (awAddr == REG_BANKRD || awAddr == REG_BITRD) wrHit = 1'b1;
  end

  // ----------------------------------------------------------------
  // Output state registers; startup image wins over bus writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dirMask <= DIR_RESET;
      genOut  <= OUT_RESET[GEN_W-1:0];
      extOut  <= OUT_RESET[STORE_W-1:GEN_W];
    end else if (loadPulse) begin
      dirMask <= loadMask;
      {extOut, genOut} <= loadOut;
    end else if (doWrite && wStrb != 4'h0) begin
      dirMask <= next_dirMask;
      genOut  <= next_genOut;
      extOut  <= next_extOut;
    end
  end

  // ----------------------------------------------------------------
  // Query selectors written through the read registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bankSel  <= BANK_GEN;
      pointSel <= PT_EXT_LO;
    end else if (doWrite && wStrb != 4'h0) begin
      if (awAddr == REG_BANKRD) bankSel <= wData[3:0];
      if (awAddr == REG_BITRD)  pointSel <= wData[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data; pins are sampled, so output banks read back the wire
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] bb;
    logic [7:0] qp;
    bb         = bankByte(bankSel, ioInS, genInS);
    qp         = decodePoint(pointSel);
    next_rdata = '0;
    rdHit      = 1'b1;
    unique case (s_axi_araddr)
      REG_DIR: next_rdata[BANKS-1:0] = dirMask;
      REG_GEN: next_rdata[GEN_W-1:0] = genOut;
      REG_BANKRD: begin
        next_rdata[7:0]     = bb[7:0];
        next_rdata[11:8]    = bankSel;
        next_rdata[ERR_BIT] = !bb[8];
      end
      REG_BITRD: begin
        if (qp[6])
          next_rdata[0] = genInS[qp[2:0]];
        else
          next_rdata[0] = ioInS[qp[5:0]];
        next_rdata[14:8]    = pointSel;
        next_rdata[ERR_BIT] = !qp[7];
      end
      REG_PERSIST: next_rdata[1:0] = {nvmValidS, loaded};
      default: begin
        rdHit = 1'b0;
        for (int g = 0; g < GROUPS; g++) begin
          if (s_axi_araddr == ADDR_W'(REG_GRP0 + 4 * g)) begin
            rdHit            = 1'b1;
            next_rdata[15:0] = extOut[g*16 +: 16];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // AXI read channel; one read in flight
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> verification/eiobp_port_props.sv
/*
  Checker for the extended I/O bank port, bound to its top module.
  Assumes one clock domain and the port's fixed AXI4-Lite timing.
*/
module eiobp_port_props
  import eiobp_pkg::*;
(
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [eiobp_pkg::DATA_W-1:0]  s_axi_rdata,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [eiobp_pkg::EXT_W-1:0]   ioOut,
  input wire logic [eiobp_pkg::EXT_W-1:0]   ioOe,
  input wire logic [eiobp_pkg::GEN_W-1:0]   genOut,
  input wire logic                          nvmStore,
  input wire logic [eiobp_pkg::BANKS-1:0]   nvmStoreMask,
  input wire logic [eiobp_pkg::STORE_W-1:0] nvmStoreOut
);
  logic [BANKS-1:0] oeMask;
  logic             oeWhole;
  logic [3:0]       upCnt;

  // Per-bank enable view; a split byte means at least one stray point
  always_comb begin
    oeWhole = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      oeMask[b] = ioOe[8*b];
      if (ioOe[8*b+:8] != {8{ioOe[8*b]}}) oeWhole = 1'b0;
    end
  end

  // Saturating age counter, keeps the startup restore out of view
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) upCnt <= 4'h0;
    else if (upCnt != 4'hF) upCnt <= upCnt + 4'h1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence bothTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence respNext;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  AST_BANK_WHOLE: assert property (oeWhole)
    else $error("bank enable split inside a byte");
  AST_INPUT_HELD: assert property (
    $stable(ioOe) |-> $stable(ioOut & ~ioOe))
    else $error("input point level moved");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_W_BLOCKED: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  AST_R_LATENCY: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_W_LATENCY: assert property (bothTaken |=> respNext)
    else $error("write answer off by a cycle");
  AST_STORE_PULSE: assert property (
    $rose(nvmStore) |-> $rose(s_axi_bvalid) ##1 !nvmStore)
    else $error("store strobe misplaced");
  AST_STORE_IMAGE: assert property (nvmStore |-> nvmStoreMask == oeMask &&
    nvmStoreOut[GEN_W-1:0] == genOut &&
    (nvmStoreOut[STORE_W-1:GEN_W] & ioOe) == (ioOut & ioOe))
    else $error("stored image differs from state");
  AST_PINS_BY_WRITE: assert property (upCnt == 4'hF &&
    !$stable({ioOe, ioOut, genOut}) |-> $rose(s_axi_bvalid))
    else $error("pins moved without a write");
endmodule

bind eiobp_port eiobp_port_props u_props (.*);

// >>> verification/eiobp_rack.sv
/*
  Mounting rack model on the far side of the extended points.
  Assumes the bench sets what the rack's switches present.
*/
module eiobp_rack
  import eiobp_pkg::*;
(
  input  wire logic [eiobp_pkg::EXT_W-1:0] ioOut,
  input  wire logic [eiobp_pkg::EXT_W-1:0] ioOe,
  input  wire logic [eiobp_pkg::EXT_W-1:0] rackIn,
  output logic      [eiobp_pkg::EXT_W-1:0] ioIn
);
  // Driven points read back the device, the rest the rack's levels
  assign ioIn = (ioOe & ioOut) | (~ioOe & rackIn);
endmodule

// >>> verification/eiobp_port_tb.sv
/*
  Self-checking bench of the I/O bank port with a rack model.
  Assumes the checker binds itself.
*/
module eiobp_port_tb
  import eiobp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [7:0]  m;
    logic [63:0] o;
    logic [7:0]  g;
  } eiobp_row_t;

  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic [ADDR_W-1:0]  awAddr = '0, arAddr = '0;
  logic [DATA_W-1:0]  wData = '0, rData;
  logic [3:0]         wStrb = 4'hF;
  logic               awValid = 0, wValid = 0, bReady = 0;
  logic               arValid = 0, rReady = 0, nvmValid = 0;
  logic               awReady, wReady, bValid, arReady, rValid, nvmStore;
  logic [1:0]         bResp, rResp, rsp;
  logic [EXT_W-1:0]   ioIn, ioOut, ioOe;
  logic [EXT_W-1:0]   rackIn = 64'h3C69_0F1E_2D4B_8796;
  logic [GEN_W-1:0]   genIn = 8'hB4, genOut;
  logic [BANKS-1:0]   nvmMask = '0, nvmStoreMask, savedM;
  logic [STORE_W-1:0] nvmOut = '0, nvmStoreOut, savedO;
  eiobp_row_t         rows [12];
  int                 err_count = 0, checks = 0, cyc = 0;
  logic [31:0]        d;

  eiobp_port dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .genIn(genIn), .genOut(genOut), .nvmValid(nvmValid), .nvmMask(nvmMask),
    .nvmOut(nvmOut), .nvmStore(nvmStore), .nvmStoreMask(nvmStoreMask),
    .nvmStoreOut(nvmStoreOut)
  );
  eiobp_rack rack (.ioOut(ioOut), .ioOe(ioOe), .rackIn(rackIn), .ioIn(ioIn));

  // Clock, hang guard and capture of the stored image
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (nvmStore === 1'b1) {savedM, savedO} <= {nvmStoreMask, nvmStoreOut};
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  function automatic logic [63:0] expand(input logic [7:0] m);
    for (int b = 0; b < 8; b++) expand[8*b+:8] = {8{m[b]}};
  endfunction

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    logic ap = 1'b1, dp = 1'b1;
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (ap || dp) begin
      @(posedge clk_sys);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
      ap = ap && awReady !== 1'b1;
      dp = dp && wReady !== 1'b1;
    end
    do @(posedge clk_sys); while (bValid !== 1'b1);
    bReady <= 1'b1;
    @(posedge clk_sys);
    r = bResp;
    bReady <= 1'b0;
  endtask

  // Read: ready is raised late on purpose, so the answer must stand
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge clk_sys); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clk_sys); while (rValid !== 1'b1);
    rReady <= 1'b1;
    @(posedge clk_sys);
    v = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask

  task automatic q(input logic [7:0] a, input logic [31:0] v, m, e);
    wr(a, v, rsp);
    rd(a, d, rsp);
    chk(rsp === RESP_OKAY && (d & m) === e, "readback");
  endtask

  task automatic doReset();
    reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    rows[0] = '{REG_DIR, 32'h0000_000C, 8'h0C, 64'h0, 8'h00};
    rows[1] = '{REG_GRP0, 32'h0000_FFFF, 8'h0C, 64'h0, 8'h00};
    rows[2] = '{8'h0C, 32'h0000_A5C3, 8'h0C, 64'hA5C3_0000, 8'h00};
    rows[3] = '{REG_BITCMD, 32'h0000_0121, 8'h0C, 64'hA5C2_0000, 8'h00};
    rows[4] = '{REG_BITCMD, 32'h0000_0011, 8'h0C, 64'hA5C2_0000, 8'h00};
    rows[5] = '{REG_BITCMD, 32'h0000_0230, 8'h0C, 64'h25C2_0000, 8'h00};
    rows[6] = '{REG_BITCMD, 32'h0001_0230, 8'h0C, 64'hA5C2_0000, 8'h00};
    rows[7] = '{REG_DIR, 32'h0000_0081, 8'h81, 64'h0, 8'h00};
    rows[8] = '{8'h14, 32'h0000_1234, 8'h81, 64'h1200_0000_0000_0000, 8'h00};
    rows[9] = '{REG_GEN, 32'h0000_005A, 8'h81, 64'h1200_0000_0000_0000, 8'h5A};
    rows[10] = '{REG_BITCMD, 32'h3, 8'h81, 64'h1200_0000_0000_0000, 8'h5E};
    rows[11] = '{REG_GRP0, 32'h8001, 8'h81, 64'h1200_0000_0000_0001, 8'h5E};
    doReset();
    chk(ioOe === 64'h0, "startup direction");
    q(REG_PERSIST, 32'h0, 32'h3, 32'h1);
    for (int i = 0; i < 12; i++) begin
      wr(rows[i].a, rows[i].d, rsp);
      chk(rsp === RESP_OKAY && ioOe === expand(rows[i].m), "direction");
      chk((ioOut & ioOe) === rows[i].o, "outputs");
      chk(genOut === rows[i].g, "general outputs");
    end
    q(REG_BANKRD, 32'h3, 32'hFFFF_FFFF, 32'h0000_0387);
    q(REG_BANKRD, 32'h9, 32'hFFFF_FFFF, 32'h0000_0912);
    q(REG_BANKRD, 32'h0, 32'hFFFF_FFFF, 32'h0000_00B4);
    q(REG_BANKRD, 32'h1, 32'h8000_0000, 32'h8000_0000);
    q(REG_BITRD, 32'h19, 32'hFFFF_FFFF, 32'h0000_1901);
    q(REG_BITRD, 32'h11, 32'hFFFF_FFFF, 32'h0000_1101);
    q(REG_BITRD, 32'h9, 32'h8000_0000, 32'h8000_0000);
    wr(8'h40, 32'hFFFF, rsp);
    rd(8'h40, d, rsp);
    chk(rsp === RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(REG_PERSIST, 32'h1, rsp);
    @(posedge clk_sys);
    chk(savedM === 8'h81, "stored mask");
    nvmValid <= 1'b1;
    nvmMask <= savedM;
    nvmOut <= savedO;
    doReset();
    chk(ioOe === expand(8'h81) && (ioOut & ioOe) === rows[11].o, "restore");
    chk(genOut === 8'h5E, "restore gen");
    q(REG_PERSIST, 32'h0, 32'h3, 32'h3);
    print_verdict();
  end
endmodule
